// [mmd_pkg.sv]
// package: memory map constants for the address decoder
package mmd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] SFR_BASE = 16'h0000;
  localparam logic [15:0] SFR_LAST = 16'h000F;
  localparam logic [15:0] P8_BASE = 16'h0010;
  localparam logic [15:0] P8_LAST = 16'h00FF;
  localparam logic [15:0] P16_BASE = 16'h0100;
  localparam logic [15:0] P16_LAST = 16'h01FF;
  localparam logic [15:0] RAM_BASE = 16'h0200;
  localparam logic [15:0] ROM_LAST = 16'hFFFF;
  localparam logic [15:0] RESET_VEC = 16'hFFFE;
  localparam int unsigned VEC_WORDS = 16;
  localparam logic [15:0] VEC_BASE = 16'hFFE0;
  localparam logic [15:0] RAM_SIZE_DEF = 16'h0800;
  localparam logic [15:0] ROM_SIZE_DEF = 16'h8000;
  localparam int unsigned OSC_STABLE_NS = 6000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_STABLE_CYC =
    (OSC_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [4:0] {
    MMD_REG_SFR  = 5'h01,
    MMD_REG_P8   = 5'h02,
    MMD_REG_P16  = 5'h04,
    MMD_REG_RAM  = 5'h08,
    MMD_REG_ROM  = 5'h10
  } mmd_region_e;
endpackage

// [mmd_mem.sv]
// memory: word-wide store with byte lanes and registered read data
`timescale 1ns/1ps
module mmd_mem #(
  parameter int unsigned WORDS = 1024
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_en,
  input  wire logic                     i_we,
  input  wire logic [1:0]               i_be,
  input  wire logic [$clog2(WORDS)-1:0] i_addr,
  input  wire logic [15:0]              i_wdata,
  output logic      [15:0]              o_rdata
);
  logic [15:0] mem [WORDS];
  always_ff @(posedge i_clk) begin
    if (i_en) begin
      if (i_we && i_be[0]) begin
        mem[i_addr][7:0] <= i_wdata[7:0];
      end
      if (i_we && i_be[1]) begin
        mem[i_addr][15:8] <= i_wdata[15:8];
      end
      o_rdata <= mem[i_addr];
    end
  end
endmodule // mmd_mem

// [mmd_decoder.sv]
// decoder: address steering, width adaptation, reset and clock readiness
`timescale 1ns/1ps
// Behaviour
// R1: code fetches must use even addresses; odd fetches are flagged and refused.
// R2: each access moves one byte or one 16-bit word.
// R3: one unified 64 KB byte address space.
// R4: program memory ends at 0FFFFh; start set by size parameter.
// R5: top 16 words of program memory are vectors, highest at 0FFFEh.
// R6: data memory starts at 0200h, sized by parameter, code and data.
// R7: 0100h-01FFh go to word-wide peripherals.
// R8: byte access to word peripherals only at even address, high byte zero.
// R9: 010h-0FFh go to byte-wide peripherals.
// R10: word read of byte peripheral returns value in low byte.
// R11: word write to byte peripheral stores low byte only.
// R12: lowest 16 bytes are byte special registers, byte access only.
// R13: words use even addresses, low byte even, high byte odd.
// R14: separate power-on reset and power-up clear outputs.
// R15: fast internal oscillator stable within 6 us of enable.
// R16: power-on reset always asserts power-up clear, never the reverse.
// R17: after power-on reset the fetch pointer starts at the 0FFFEh vector.
// R18: gap accesses complete and read zero.
module mmd_decoder #(
  parameter logic [15:0] RAM_SIZE = mmd_pkg::RAM_SIZE_DEF,
  parameter logic [15:0] ROM_SIZE = mmd_pkg::ROM_SIZE_DEF,
  parameter int unsigned RAM_WORDS = 1024
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_por_evt,
  input  wire logic        i_clr_evt,
  input  wire logic        i_osc_en,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic        i_byte,
  input  wire logic        i_fetch,
  input  wire logic [15:0] i_shared_address_bus,
  input  wire logic [15:0] i_shared_data_bus,
  output logic      [15:0] o_shared_data_bus,
  output logic             o_ack,
  output logic             o_align_err,
  output logic             o_power_on_reset,
  output logic             o_power_up_clear,
  output logic             o_osc_ready,
  output logic      [15:0] o_boot_addr,
  output logic             o_sfr_sel,
  output logic             o_p8_sel,
  output logic             o_p16_sel,
  output logic             o_rom_sel,
  output logic             o_per_we,
  output logic      [1:0]  o_per_be,
  output logic      [15:0] o_per_addr,
  output logic      [15:0] o_per_wdata,
  input  wire logic [7:0]  i_sfr_rdata,
  input  wire logic [7:0]  i_p8_rdata,
  input  wire logic [15:0] i_p16_rdata,
  input  wire logic [15:0] i_rom_rdata
);
  localparam logic [15:0] RAM_LAST = mmd_pkg::RAM_BASE + RAM_SIZE - 16'h0001;
  localparam logic [15:0] ROM_BASE = mmd_pkg::ROM_LAST - ROM_SIZE + 16'h0001;
  localparam int unsigned RAW = $clog2(RAM_WORDS);
  localparam int unsigned OSC_W = $clog2(mmd_pkg::OSC_STABLE_CYC + 1);

  // refuse sizes the decode cannot serve, before anything runs
  if (RAM_SIZE == 16'h0000 || ROM_SIZE < 16'h0020) begin : g_bad_sizes
    $error("bad sizes");
  end
  if ({RAM_WORDS, 1'b0} < 33'(RAM_SIZE)) begin : g_ram_small
    $error("ram array too small");
  end
  if (RAM_LAST >= ROM_BASE) begin : g_overlap
    $error("ram overlaps program memory");
  end

  typedef struct packed {
    logic        por_m;
    logic        por_s;
    logic        por_r;
    logic        clr_m;
    logic        clr_s;
    logic        clr_r;
    logic        clr_f;
    logic        por;
    logic        power_up_clear;
    logic [OSC_W-1:0] osc_cnt;
    logic        ready;
    logic        ack;
    logic        err;
    logic        hi;
    logic        zero;
    logic        hi_zero;
    mmd_pkg::mmd_region_e reg_sel;
    logic        gap;
    logic [15:0] boot;
  } mmd_state_s;

  mmd_state_s s_q;
  mmd_state_s s_d;

  logic        in_sfr;
  logic        in_p8;
  logic        in_p16;
  logic        in_ram;
  logic        in_rom;
  logic        odd;
  logic        bad;
  logic        go;
  logic [1:0]  be;
  logic [15:0] wdata;
  logic [15:0] ram_rdata;
  logic [15:0] sel_rd;

  // full 16-bit compare spans exactly 64 KB, nothing aliases
  assign in_sfr = i_shared_address_bus <= mmd_pkg::SFR_LAST; // R12 R3
  assign in_p8  = i_shared_address_bus >= mmd_pkg::P8_BASE &&
                  i_shared_address_bus <= mmd_pkg::P8_LAST; // R9
  assign in_p16 = i_shared_address_bus >= mmd_pkg::P16_BASE &&
                  i_shared_address_bus <= mmd_pkg::P16_LAST; // R7
  assign in_ram = i_shared_address_bus >= mmd_pkg::RAM_BASE &&
                  i_shared_address_bus <= RAM_LAST; // R6
  assign in_rom = i_shared_address_bus >= ROM_BASE; // R4 R5
  assign odd = i_shared_address_bus[0];

  // misaligned or wrong-width accesses still complete but touch nothing
  always_comb begin
    bad = 1'b0;
    if (odd && (i_fetch || !i_byte)) begin
      bad = 1'b1; // R1 R13
    end
    if (in_sfr && !i_byte) begin
      bad = 1'b1; // R12
    end
    if (in_p16 && i_byte && odd) begin
      bad = 1'b1; // R8
    end
  end

  assign go = i_req && !bad && !s_q.power_up_clear;

  // byte lanes follow little-endian order
  always_comb begin
    if (!i_byte) begin
      be = 2'b11; // R2 R13
    end else begin
      be = odd ? 2'b10 : 2'b01;
    end
    if (in_sfr || in_p8) begin
      be = 2'b01; // R11
    end
    if (i_byte && odd) begin
      wdata = {i_shared_data_bus[7:0], i_shared_data_bus[7:0]};
    end else begin
      wdata = i_shared_data_bus;
    end
  end

  assign o_sfr_sel   = go && in_sfr;
  assign o_p8_sel    = go && in_p8;
  assign o_p16_sel   = go && in_p16;
  assign o_rom_sel   = go && in_rom;
  assign o_per_we    = go && i_we && !in_rom;
  assign o_per_be    = be;
  assign o_per_addr  = i_shared_address_bus;
  // byte-wide units see their byte on the low lane
  assign o_per_wdata = (in_sfr || in_p8) && odd ?
                       {8'h00, i_shared_data_bus[7:0]} : wdata;

  mmd_mem #(
    .WORDS (RAM_WORDS)
  ) u_ram (
    .i_clk   (i_clk),
    .i_en    (go && in_ram),
    .i_we    (i_we),
    .i_be    (be),
    .i_addr  (RAW'((i_shared_address_bus - mmd_pkg::RAM_BASE) >> 1)),
    .i_wdata (wdata),
    .o_rdata (ram_rdata)
  );

  // one cycle later: pick the region that was addressed
  always_comb begin
    case (s_q.reg_sel)
      mmd_pkg::MMD_REG_SFR: sel_rd = {8'h00, i_sfr_rdata};
      mmd_pkg::MMD_REG_P8:  sel_rd = {8'h00, i_p8_rdata}; // R10
      mmd_pkg::MMD_REG_P16: sel_rd = i_p16_rdata;
      mmd_pkg::MMD_REG_RAM: sel_rd = ram_rdata;
      mmd_pkg::MMD_REG_ROM: sel_rd = i_rom_rdata;
      default:              sel_rd = 16'h0000;
    endcase
    if (s_q.gap || s_q.zero) begin
      sel_rd = 16'h0000; // R18
    end else if (s_q.hi) begin
      sel_rd = {8'h00, sel_rd[15:8]}; // R13
    end else if (s_q.hi_zero) begin
      sel_rd = {8'h00, sel_rd[7:0]}; // R8
    end
  end

  always_comb begin
    s_d = s_q;
    // pins from outside pass three flops; change counts when 2nd and 3rd agree
    s_d.por_m = i_por_evt;
    s_d.por_s = s_q.por_m;
    s_d.por_r = s_q.por_s;
    s_d.clr_m = i_clr_evt;
    s_d.clr_s = s_q.clr_m;
    s_d.clr_r = s_q.clr_s;
    // a level only counts once the 2nd and 3rd flops agree, else hold
    s_d.por = (s_q.por_s == s_q.por_r) ? s_q.por_s : s_q.por; // R14
    s_d.clr_f = (s_q.clr_s == s_q.clr_r) ? s_q.clr_s : s_q.clr_f;
    s_d.power_up_clear = s_d.por || s_d.clr_f; // R16
    if (s_q.por) begin
      s_d.boot = mmd_pkg::RESET_VEC; // R17
    end
    // readiness after enable; counts at 10 ns per cycle
    if (!i_osc_en) begin
      s_d.osc_cnt = '0;
      s_d.ready = 1'b0;
    end else if (s_q.osc_cnt == OSC_W'(mmd_pkg::OSC_STABLE_CYC)) begin
      s_d.ready = 1'b1; // R15
    end else begin
      s_d.osc_cnt = s_q.osc_cnt + OSC_W'(1);
    end
    s_d.ack = i_req && !s_q.power_up_clear; // R18
    s_d.err = i_req && bad && !s_q.power_up_clear;
    s_d.hi = i_byte && odd && !in_sfr && !in_p8;
    s_d.zero = bad || i_we;
    s_d.hi_zero = in_p16 && i_byte; // R8
    s_d.gap = !(in_sfr || in_p8 || in_p16 || in_ram || in_rom);
    if (in_sfr) begin
      s_d.reg_sel = mmd_pkg::MMD_REG_SFR;
    end else if (in_p8) begin
      s_d.reg_sel = mmd_pkg::MMD_REG_P8;
    end else if (in_p16) begin
      s_d.reg_sel = mmd_pkg::MMD_REG_P16;
    end else if (in_ram) begin
      s_d.reg_sel = mmd_pkg::MMD_REG_RAM;
    end else begin
      s_d.reg_sel = mmd_pkg::MMD_REG_ROM;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.por <= 1'b1;
      s_q.power_up_clear <= 1'b1;
      s_q.reg_sel <= mmd_pkg::MMD_REG_SFR;
      s_q.boot <= mmd_pkg::RESET_VEC;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ack            = s_q.ack;
  assign o_align_err      = s_q.err;
  assign o_shared_data_bus = s_q.ack ? sel_rd : 16'h0000;
  assign o_power_on_reset = s_q.por;
  assign o_power_up_clear = s_q.power_up_clear;
  assign o_osc_ready      = s_q.ready;
  assign o_boot_addr      = s_q.boot;
endmodule // mmd_decoder

// [mmd_decoder_assertions.sv]
// checker: port-level timing and decode relations of the decoder
`timescale 1ns/1ps
module mmd_decoder_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_req,
  input wire logic        i_we,
  input wire logic        i_byte,
  input wire logic        i_fetch,
  input wire logic        i_osc_en,
  input wire logic [15:0] i_shared_address_bus,
  input wire logic [15:0] o_shared_data_bus,
  input wire logic        o_ack,
  input wire logic        o_align_err,
  input wire logic        o_power_on_reset,
  input wire logic        o_power_up_clear,
  input wire logic        o_osc_ready,
  input wire logic        o_p8_sel,
  input wire logic [1:0]  o_per_be
);
  logic [15:0] a;
  logic        p8;
  logic        p16;
  assign a = i_shared_address_bus;
  assign p8 = a >= mmd_pkg::P8_BASE && a <= mmd_pkg::P8_LAST;
  assign p16 = a >= mmd_pkg::P16_BASE && a <= mmd_pkg::P16_LAST;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_take;
    i_req && !o_power_up_clear;
  endsequence
  sequence s_err;
    o_ack && o_align_err;
  endsequence
  AST_ACK: assert property (s_take |=> o_ack)
    else $error("access not answered");
  AST_PUC: assert property (i_req && o_power_up_clear |=> !o_ack)
    else $error("access answered during clear");
  AST_FETCH: assert property (s_take ##0 (i_fetch && a[0]) |=> s_err)
    else $error("odd fetch not refused");
  AST_WORD: assert property (s_take ##0 (!i_byte && a[0]) |=> s_err)
    else $error("odd word not refused");
  AST_SFRW: assert property (s_take ##0 (!i_byte && a < 16'h0010)
    |=> s_err)
    else $error("word to special regs not refused");
  AST_P16B: assert property (s_take ##0 (i_byte && !i_we && !a[0] && p16)
    |=> !o_align_err && o_shared_data_bus[15:8] == 8'h00)
    else $error("byte read of word periph bad");
  AST_P8SEL: assert property (s_take ##0 (i_byte && !i_fetch && p8)
    |-> o_p8_sel)
    else $error("byte periph not selected");
  AST_BE: assert property (s_take ##0 (i_we && !i_byte && !a[0] && p8)
    |-> o_per_be == 2'b01)
    else $error("word write to byte periph not low lane");
  AST_POR: assert property (o_power_on_reset |-> o_power_up_clear)
    else $error("power-on reset without clear");
  AST_OSC: assert property ($rose(i_osc_en) |-> ##[1:601] o_osc_ready)
    else $error("oscillator not ready in time");
endmodule // mmd_decoder_chk

bind mmd_decoder mmd_decoder_chk i_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_we(i_we),
  .i_byte(i_byte), .i_fetch(i_fetch), .i_osc_en(i_osc_en),
  .i_shared_address_bus(i_shared_address_bus),
  .o_shared_data_bus(o_shared_data_bus), .o_ack(o_ack),
  .o_align_err(o_align_err), .o_power_on_reset(o_power_on_reset),
  .o_power_up_clear(o_power_up_clear), .o_osc_ready(o_osc_ready),
  .o_p8_sel(o_p8_sel), .o_per_be(o_per_be));

// [mmd_periph_model.sv]
// partner: peripheral and program memory read responders
`timescale 1ns/1ps
module mmd_periph_model (
  input  wire logic        i_clk,
  input  wire logic        i_sfr_sel,
  input  wire logic        i_p8_sel,
  input  wire logic        i_p16_sel,
  input  wire logic        i_rom_sel,
  input  wire logic [15:0] i_addr,
  output logic      [7:0]  o_sfr_rdata,
  output logic      [7:0]  o_p8_rdata,
  output logic      [15:0] o_p16_rdata,
  output logic      [15:0] o_rom_rdata
);
  logic [7:0]  b;
  logic [15:0] w;
  assign b = i_addr[7:0] ^ 8'h96;
  assign w = {i_addr[15:8] ^ 8'hC3, {i_addr[7:1], 1'b0} ^ 8'h5A};
  initial {o_sfr_rdata, o_p8_rdata, o_p16_rdata, o_rom_rdata} = '0;
  // unselected data flips every cycle so a stale read never matches
  always @(posedge i_clk) begin
    o_sfr_rdata <= i_sfr_sel ? b : ~o_sfr_rdata;
    o_p8_rdata <= i_p8_sel ? b : ~o_p8_rdata;
    o_p16_rdata <= i_p16_sel ? w : ~o_p16_rdata;
    o_rom_rdata <= i_rom_sel ? w : ~o_rom_rdata;
  end
endmodule // mmd_periph_model

// [memory_map_address_decoder_bench.sv]
// bench: random and corner accesses through the address decoder
`timescale 1ns/1ps
module memory_map_address_decoder_bench;
  logic clk, rst, por, clr, osc, req, we, byt, fe, ack, err;
  logic pon, power_up_clear, rdy, ss, s8, s16, sr, e, pwe;
  logic [15:0] adr, wd, rdat, boot, pa, d16, drom, r, a, d, pwd, pd;
  logic [1:0] pbe;
  logic [2:0] ps;
  logic [7:0] dsfr, d8;
  logic [15:0] ram [logic [15:0]];
  int bad_count, num_checks, i;
  mmd_decoder i_dut (.i_clk(clk), .i_sys_rst(rst), .i_por_evt(por),
    .i_clr_evt(clr), .i_osc_en(osc), .i_req(req), .i_we(we),
    .i_byte(byt), .i_fetch(fe), .i_shared_address_bus(adr),
    .i_shared_data_bus(wd), .o_shared_data_bus(rdat), .o_ack(ack),
    .o_align_err(err), .o_power_on_reset(pon), .o_power_up_clear(power_up_clear),
    .o_osc_ready(rdy), .o_boot_addr(boot), .o_sfr_sel(ss),
    .o_p8_sel(s8), .o_p16_sel(s16), .o_rom_sel(sr), .o_per_we(pwe),
    .o_per_be(pbe), .o_per_addr(pa), .o_per_wdata(pwd),
    .i_sfr_rdata(dsfr), .i_p8_rdata(d8), .i_p16_rdata(d16),
    .i_rom_rdata(drom));
  mmd_periph_model i_mdl (.i_clk(clk), .i_sfr_sel(ss), .i_p8_sel(s8),
    .i_p16_sel(s16), .i_rom_sel(sr), .i_addr(pa), .o_sfr_rdata(dsfr),
    .o_p8_rdata(d8), .o_p16_rdata(d16), .o_rom_rdata(drom));
  function automatic logic [15:0] pw(input logic [15:0] x);
    return {x[15:8] ^ 8'hC3, {x[7:1], 1'b0} ^ 8'h5A};
  endfunction
  function automatic logic [15:0] pb(input logic [15:0] x);
    return {8'h00, x[7:0] ^ 8'h96};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic acc(input logic w, b, f, input logic [15:0] ad, dd);
    {req, we, byt, fe, adr, wd} = {1'b1, w, b, f, ad, dd};
    #1;
    ps = {pwe, pbe};
    pd = pwd;
    @(negedge clk);
    chk(ack, 1'b1);
    r = rdat;
    e = err;
  endtask
  task automatic rchk(input logic b, f, input logic [15:0] ad, x, m,
                      input logic xe);
    acc(1'b0, b, f, ad, 16'h0000);
    chk(r & m, x);
    chk(e, xe);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_clear;
    req = 0;
    for (i = 0; i < 50 && power_up_clear; i++) @(negedge clk);
    chk(power_up_clear, 1'b0);
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {rst, por, clr, osc, req, we, byt, fe, adr, wd} = {4'h8, 36'h0};
    i = $urandom(32'h6DF7);
    repeat (5) @(negedge clk);
    rst = 0;
    osc = 1;
    wait_clear;
    chk(boot, 16'hFFFE);
    for (int k = 0; k < 24; k++) begin
      a = {5'h00, 10'($urandom), 1'b0} + 16'h0200;
      d = 16'($urandom);
      acc(1'b1, 1'b0, 1'b0, a, d);
      ram[a] = d;
      d = 16'($urandom);
      acc(1'b1, 1'b1, 1'b0, a | 16'(k & 1), d);
      if (k & 1) ram[a][15:8] = d[7:0];
      else ram[a][7:0] = d[7:0];
      chk(ps, (k & 1) ? 3'b110 : 3'b101);
    end
    foreach (ram[k]) begin
      rchk(1'b0, 1'b0, k, ram[k], 16'hFFFF, 1'b0);
      rchk(1'b0, 1'b1, k, ram[k], 16'hFFFF, 1'b0);
      rchk(1'b1, 1'b0, k | 16'h0001, ram[k] >> 8, 16'h00FF, 1'b0);
    end
    rchk(1'b0, 1'b1, 16'hFFFE, pw(16'hFFFE), 16'hFFFF, 1'b0);
    rchk(1'b0, 1'b0, 16'hFFE0, pw(16'hFFE0), 16'hFFFF, 1'b0);
    rchk(1'b0, 1'b0, 16'h0150, pw(16'h0150), 16'hFFFF, 1'b0);
    rchk(1'b1, 1'b0, 16'h0152, pw(16'h0152) & 16'h00FF, 16'hFFFF, 1'b0);
    rchk(1'b1, 1'b0, 16'h0153, 16'h0000, 16'hFFFF, 1'b1);
    rchk(1'b0, 1'b0, 16'h0004, 16'h0000, 16'hFFFF, 1'b1);
    rchk(1'b1, 1'b0, 16'h0005, pb(16'h0005), 16'h00FF, 1'b0);
    rchk(1'b1, 1'b0, 16'h0033, pb(16'h0033), 16'h00FF, 1'b0);
    rchk(1'b0, 1'b0, 16'h0034, pb(16'h0034), 16'h00FF, 1'b0);
    rchk(1'b0, 1'b0, 16'h4000, 16'h0000, 16'hFFFF, 1'b0);
    rchk(1'b0, 1'b0, 16'h0203, 16'h0000, 16'hFFFF, 1'b1);
    rchk(1'b0, 1'b1, 16'h8001, 16'h0000, 16'hFFFF, 1'b1);
    rchk(1'b1, 1'b0, 16'hFFFF, pw(16'hFFFE) >> 8, 16'h00FF, 1'b0);
    acc(1'b1, 1'b1, 1'b0, 16'h0033, 16'h00EF);
    chk(ps, 3'b101);
    chk(pd, 16'h00EF);
    acc(1'b1, 1'b0, 1'b0, 16'hFFF0, 16'h1234);
    chk(ps[2], 1'b0);
    acc(1'b1, 1'b0, 1'b0, 16'h0040, 16'hABCD);
    chk(r, 16'h0000);
    chk(ps, 3'b101);
    chk(pd[7:0], 8'hCD);
    req = 0;
    for (i = 0; i < 700 && !rdy; i++) @(negedge clk);
    chk(rdy, 1'b1);
    por = 1;
    repeat (6) @(negedge clk);
    chk({pon, power_up_clear}, 2'b11);
    chk(boot, 16'hFFFE);
    req = 1;
    @(negedge clk);
    chk(ack, 1'b0);
    por = 0;
    wait_clear;
    clr = 1;
    repeat (6) @(negedge clk);
    chk({pon, power_up_clear}, 2'b01);
    clr = 0;
    wait_clear;
    tally_and_finish;
  end
endmodule // memory_map_address_decoder_bench
